// ---- rtl/exec_pkg.sv ----
package exec_pkg;

    // Operation codes presented to the execution unit
    typedef enum logic [4:0] {
        OP_IDLE_INSTRUCTION      = 5'h00,
        OP_ALTERNATE_SPACE_XFER  = 5'h01,
        OP_SIGNED_MULTIPLY       = 5'h02,
        OP_UNSIGNED_MULTIPLY     = 5'h03,
        OP_DECIMAL_ZERO_MINUS    = 5'h04,
        OP_TWOS_COMPLEMENT_INV   = 5'h05,
        OP_ZERO_MINUS_WITH_EXT   = 5'h06,
        OP_BIT_INVERT            = 5'h07,
        OP_UNION                 = 5'h08,
        OP_IMMEDIATE_UNION       = 5'h09,
        OP_IMM_UNION_CCB         = 5'h0a,
        OP_IMM_UNION_STATUS_WORD = 5'h0b,
        OP_BCD_COMPRESS          = 5'h0c,
        OP_PUSH_EFFECTIVE_ADDR   = 5'h0d,
        OP_TRANSLATION_INVAL     = 5'h0e,
        OP_TRANSLATION_PRELOAD   = 5'h0f,
        OP_MMU_REGISTER_XFER     = 5'h10,
        OP_TRANSLATION_PROBE     = 5'h11,
        OP_RESET_DEVICES         = 5'h12,
        OP_ROTATE_LEFT           = 5'h13,
        OP_ROTATE_RIGHT          = 5'h14,
        OP_EXTENDED_ROTATE_LEFT  = 5'h15,
        OP_EXTENDED_ROTATE_RIGHT = 5'h16
    } op_e;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } size_e;

    // One instruction with its operands already fetched
    typedef struct packed {
        op_e         op;
        size_e       size;
        logic        to_mem;
        logic        pair;
        logic [1:0]  mmu_register_select;
        logic [5:0]  count;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] imm;
        logic [31:0] ea;
    } req_s;

    // Effects of one instruction
    typedef struct packed {
        logic        trap;
        logic        wr_dst;
        logic        wr_hi;
        logic        wr_mem;
        logic        rd_mem;
        logic        wr_ptr;
        logic [2:0]  fc;
        logic [31:0] result;
        logic [31:0] result_hi;
        logic [31:0] addr;
        logic [31:0] ptr;
    } rsp_s;

    // Register map, byte addresses
    localparam logic [7:0] REG_SOURCE_FC   = 8'h00;
    localparam logic [7:0] REG_DEST_FC     = 8'h04;
    localparam logic [7:0] REG_STATUS_WORD = 8'h08;
    localparam logic [7:0] REG_TSR         = 8'h0c;
    localparam logic [7:0] REG_TRAP_COUNT  = 8'h10;
    localparam logic [7:0] REG_MMU_BASE    = 8'h20;

    localparam int          SR_SUPER_BIT     = 13;
    localparam int          SR_X_BIT         = 4;
    localparam logic [15:0] SR_RESET         = 16'h2700;
    localparam logic [15:0] CCB_MASK         = 16'h001f;
    localparam logic [15:0] SR_MASK          = 16'ha71f;
    localparam logic [31:0] MASK_BYTE        = 32'h000000ff;
    localparam logic [31:0] MASK_WORD        = 32'h0000ffff;
    localparam logic [31:0] MASK_LONG        = 32'hffffffff;
    localparam logic [31:0] PUSH_STEP        = 32'h00000004;
    localparam logic [31:0] BCD_COMPRESS_STEP        = 32'h00000001;
    localparam logic [4:0]  BCD_ADJUST       = 5'h06;
    localparam int          PAGE_LSB         = 12;
    localparam int          RESET_OUT_CYCLES = 124;

endpackage

// ---- rtl/instruction_semantics_m_to_r.sv ----
`timescale 1ns/100ps

module instruction_semantics_m_to_r
    import exec_pkg::*;
#(
    parameter int TC_ENTRIES   = 4,
    parameter int RESET_CYCLES = RESET_OUT_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        REQ_VALID,
    input  wire req_s        REQ,
    output logic             RSP_VALID,
    output rsp_s             RSP,
    output logic             RESET_OUT,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA
);

    localparam int PTR_W = (TC_ENTRIES > 1) ? $clog2(TC_ENTRIES) : 1;
    localparam int TAG_W = 32 - PAGE_LSB;

    logic [15:0]      status_word;
    logic [2:0]       source_function_code;
    logic [2:0]       destination_function_code;
    logic [31:0]      translation_status_reg;
    logic [31:0]      trap_count;
    logic [31:0]      mmu_regs [4];
    logic             tc_valid [TC_ENTRIES];
    logic [TAG_W-1:0] tc_tag   [TC_ENTRIES];
    logic [TAG_W-1:0] tc_phys  [TC_ENTRIES];
    logic [PTR_W-1:0] victim;
    logic [TC_ENTRIES-1:0] hit_vec;
    logic             hit_any;
    logic [PTR_W-1:0] hit_idx;
    logic [TAG_W-1:0] hit_phys;
    logic [31:0]      rst_cnt;

    logic             supervisor;
    logic             priv_op;
    logic             trap;
    logic             go;
    logic [31:0]      mask;
    logic [31:0]      merged;
    logic [31:0]      op_out;
    logic             x_in;
    logic             next_x;
    logic             x_write;
    logic [15:0]      next_sr;
    rsp_s             next_rsp;
    logic [63:0]      product;
    logic [31:0]      mul_a;
    logic [31:0]      mul_b;
    logic [32:0]      rot_val;
    logic [5:0]       rot_cnt;
    logic [4:0]       bcd_lo;
    logic [4:0]       bcd_hi;
    logic [15:0]      bcd_compress_sum;

    // One rotate step; bit 32 carries the extend bit
    function automatic logic [32:0] rot1(logic [32:0] v, size_e sz,
                                         logic left, logic thru);
        logic [31:0] d;
        logic        x;
        logic        out;
        int          msb;
        d   = v[31:0];
        x   = v[32];
        msb = (sz == SZ_BYTE) ? 7 : (sz == SZ_WORD) ? 15 : 31;
        if (left) begin
            out  = d[msb];
            d    = d << 1;
            d[0] = thru ? x : out;
        end else begin
            out    = d[0];
            d      = d >> 1;
            d[msb] = thru ? x : out;
        end
        if (thru) begin
            x = out;
        end
        return {x, d};
    endfunction

    assign supervisor = status_word[SR_SUPER_BIT];
    assign x_in       = status_word[SR_X_BIT];

    // Privileged operations
    always_comb begin
        case (REQ.op)
            OP_ALTERNATE_SPACE_XFER, OP_IMM_UNION_STATUS_WORD,
            OP_TRANSLATION_INVAL, OP_TRANSLATION_PRELOAD,
            OP_MMU_REGISTER_XFER, OP_TRANSLATION_PROBE,
            OP_RESET_DEVICES: priv_op = 1'b1;
            default:          priv_op = 1'b0;
        endcase
    end

    // Trap checked before any effect is allowed
    assign trap = REQ_VALID && priv_op && !supervisor;
    assign go   = REQ_VALID && !trap;

    // Translation cache lookup per entry
    genvar g;
    generate
        for (g = 0; g < TC_ENTRIES; g++) begin : g_match
            assign hit_vec[g] = tc_valid[g] &&
                                tc_tag[g] == REQ.ea[31:PAGE_LSB];
        end
    endgenerate

    // First matching entry
    always_comb begin
        hit_idx  = '0;
        hit_phys = '0;
        for (int i = TC_ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_idx  = PTR_W'(i);
                hit_phys = tc_phys[i];
            end
        end
    end
    assign hit_any = |hit_vec;

    // Operand width mask
    always_comb begin
        case (REQ.to_mem && REQ.op >= OP_ROTATE_LEFT ? SZ_WORD : REQ.size)
            SZ_BYTE: mask = MASK_BYTE;
            SZ_WORD: mask = MASK_WORD;
            default: mask = MASK_LONG;
        endcase
    end

    // Multiplier operands, word forms extended to 32 bits
    always_comb begin
        logic sgn;
        sgn = (REQ.op == OP_SIGNED_MULTIPLY);
        if (REQ.size == SZ_WORD) begin
            mul_a = {{16{sgn & REQ.src[15]}}, REQ.src[15:0]};
            mul_b = {{16{sgn & REQ.dst[15]}}, REQ.dst[15:0]};
        end else begin
            mul_a = REQ.src;
            mul_b = REQ.dst;
        end
        product = {{32{sgn & mul_a[31]}}, mul_a} *
                  {{32{sgn & mul_b[31]}}, mul_b};
    end

    // Decimal zero minus on the low byte
    always_comb begin
        bcd_lo = 5'h00 - {1'b0, REQ.dst[3:0]} - {4'h0, x_in};
        if (bcd_lo[4]) begin
            bcd_lo = bcd_lo - BCD_ADJUST;
        end
        bcd_hi = 5'h00 - {1'b0, REQ.dst[7:4]} - {4'h0, bcd_lo[4]};
        if (bcd_hi[4]) begin
            bcd_hi = bcd_hi - BCD_ADJUST;
        end
    end

    // Unpacked pair plus adjustment
    assign bcd_compress_sum = REQ.src[15:0] + REQ.imm[15:0];

    // Rotates; memory form is one step on a word
    always_comb begin
        logic left;
        logic thru;
        left    = (REQ.op == OP_ROTATE_LEFT) ||
                  (REQ.op == OP_EXTENDED_ROTATE_LEFT);
        thru    = (REQ.op == OP_EXTENDED_ROTATE_LEFT) ||
                  (REQ.op == OP_EXTENDED_ROTATE_RIGHT);
        rot_cnt = REQ.to_mem ? 6'h01 : REQ.count;
        rot_val = {x_in, REQ.dst};
        for (int i = 0; i < 64; i++) begin
            if (6'(i) < rot_cnt) begin
                rot_val = rot1(rot_val,
                               REQ.to_mem ? SZ_WORD : REQ.size,
                               left, thru);
            end
        end
    end

    // Execute one instruction
    always_comb begin
        next_rsp      = '0;
        next_rsp.trap = trap;
        next_rsp.addr = REQ.ea;
        next_sr       = status_word;
        next_x        = x_in;
        x_write       = 1'b0;
        op_out        = REQ.dst;
        case (REQ.op)
            OP_ALTERNATE_SPACE_XFER: begin
                next_rsp.result = REQ.src;
                next_rsp.wr_mem = REQ.to_mem;
                next_rsp.rd_mem = !REQ.to_mem;
                next_rsp.fc     = REQ.to_mem ?
                                  destination_function_code :
                                  source_function_code;
            end
            OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY: begin
                next_rsp.result    = product[31:0];
                next_rsp.result_hi = product[63:32];
                next_rsp.wr_dst    = 1'b1;
                next_rsp.wr_hi     = REQ.pair &&
                                     REQ.size == SZ_LONG;
            end
            OP_DECIMAL_ZERO_MINUS: begin
                op_out  = {24'h0, bcd_hi[3:0], bcd_lo[3:0]};
                next_x  = bcd_hi[4];
                x_write = 1'b1;
            end
            OP_TWOS_COMPLEMENT_INV: begin
                op_out  = 32'h0 - REQ.dst;
                next_x  = |(REQ.dst & mask);
                x_write = 1'b1;
            end
            OP_ZERO_MINUS_WITH_EXT: begin
                op_out  = 32'h0 - REQ.dst - {31'h0, x_in};
                next_x  = |(REQ.dst & mask) | x_in;
                x_write = 1'b1;
            end
            OP_BIT_INVERT:      op_out = ~REQ.dst;
            OP_UNION:           op_out = REQ.src | REQ.dst;
            OP_IMMEDIATE_UNION: op_out = REQ.imm | REQ.dst;
            OP_IMM_UNION_CCB: begin
                next_sr = status_word |
                          (REQ.imm[15:0] & CCB_MASK);
            end
            OP_IMM_UNION_STATUS_WORD: begin
                if (!trap) begin
                    next_sr = status_word |
                              (REQ.imm[15:0] & SR_MASK);
                end
            end
            OP_BCD_COMPRESS: begin
                next_rsp.result = {24'h0, bcd_compress_sum[11:8],
                                   bcd_compress_sum[3:0]};
                next_rsp.wr_dst = !REQ.to_mem;
                next_rsp.wr_mem = REQ.to_mem;
                next_rsp.wr_ptr = REQ.to_mem;
                next_rsp.ptr    = REQ.ea - BCD_COMPRESS_STEP;
                next_rsp.addr   = REQ.ea - BCD_COMPRESS_STEP;
            end
            OP_PUSH_EFFECTIVE_ADDR: begin
                next_rsp.ptr    = REQ.dst - PUSH_STEP;
                next_rsp.addr   = REQ.dst - PUSH_STEP;
                next_rsp.result = REQ.ea;
                next_rsp.wr_ptr = 1'b1;
                next_rsp.wr_mem = 1'b1;
            end
            OP_MMU_REGISTER_XFER: begin
                next_rsp.result = mmu_regs[REQ.mmu_register_select];
                next_rsp.wr_dst = !REQ.to_mem && !trap;
                next_rsp.wr_mem = REQ.to_mem && !trap;
            end
            OP_ROTATE_LEFT, OP_ROTATE_RIGHT: op_out = rot_val[31:0];
            OP_EXTENDED_ROTATE_LEFT, OP_EXTENDED_ROTATE_RIGHT: begin
                op_out  = rot_val[31:0];
                next_x  = rot_val[32];
                x_write = rot_cnt != 6'h00;
            end
            default: ;
        endcase
        // Sized result keeps the untouched upper bits
        merged = (REQ.dst & ~mask) | (op_out & mask);
        if (REQ.op inside {OP_DECIMAL_ZERO_MINUS, OP_TWOS_COMPLEMENT_INV,
                           OP_ZERO_MINUS_WITH_EXT, OP_BIT_INVERT,
                           OP_UNION, OP_IMMEDIATE_UNION,
                           OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
                           OP_EXTENDED_ROTATE_LEFT,
                           OP_EXTENDED_ROTATE_RIGHT}) begin
            next_rsp.result = merged;
            next_rsp.wr_dst = !REQ.to_mem;
            next_rsp.wr_mem = REQ.to_mem;
        end
        if (x_write) begin
            next_sr[SR_X_BIT] = next_x;
        end
        if (trap) begin
            next_rsp.wr_dst = 1'b0;
            next_rsp.wr_hi  = 1'b0;
            next_rsp.wr_mem = 1'b0;
            next_rsp.rd_mem = 1'b0;
            next_rsp.wr_ptr = 1'b0;
        end
    end

    // Answer one cycle after the request
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RSP_VALID <= 1'b0;
            RSP       <= '0;
        end else begin
            RSP_VALID <= REQ_VALID;
            RSP       <= REQ_VALID ? next_rsp : '0;
        end
    end

    // Status word; bus write has priority
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            status_word <= SR_RESET;
        end else if (REG_WR && REG_ADDR == REG_STATUS_WORD) begin
            status_word <= REG_WDATA[15:0];
        end else if (go) begin
            status_word <= next_sr;
        end
    end

    // Function code registers
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            source_function_code      <= 3'h0;
            destination_function_code <= 3'h0;
        end else if (REG_WR) begin
            if (REG_ADDR == REG_SOURCE_FC) begin
                source_function_code <= REG_WDATA[2:0];
            end
            if (REG_ADDR == REG_DEST_FC) begin
                destination_function_code <= REG_WDATA[2:0];
            end
        end
    end

    // MMU registers
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < 4; i++) begin
                mmu_regs[i] <= 32'h0;
            end
        end else if (go && REQ.op == OP_MMU_REGISTER_XFER &&
                     !REQ.to_mem) begin
            mmu_regs[REQ.mmu_register_select] <= REQ.src;
        end
    end

    // Translation cache maintenance
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            victim <= '0;
            for (int i = 0; i < TC_ENTRIES; i++) begin
                tc_valid[i] <= 1'b0;
                tc_tag[i]   <= '0;
                tc_phys[i]  <= '0;
            end
        end else if (go) begin
            if (REQ.op == OP_TRANSLATION_INVAL) begin
                for (int i = 0; i < TC_ENTRIES; i++) begin
                    if (hit_vec[i]) begin
                        tc_valid[i] <= 1'b0;
                    end
                end
            end
            if (REQ.op == OP_TRANSLATION_PRELOAD ||
                (REQ.op == OP_TRANSLATION_PROBE && !hit_any)) begin
                if (hit_any) begin
                    tc_phys[hit_idx] <= REQ.src[31:PAGE_LSB];
                end else begin
                    tc_valid[victim] <= 1'b1;
                    tc_tag[victim]   <= REQ.ea[31:PAGE_LSB];
                    tc_phys[victim]  <= REQ.src[31:PAGE_LSB];
                    victim <= (victim == PTR_W'(TC_ENTRIES - 1)) ?
                              '0 : victim + PTR_W'(1);
                end
            end
        end
    end

    // Probe status: hit flag and physical page
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            translation_status_reg <= 32'h0;
        end else if (go && REQ.op == OP_TRANSLATION_PROBE) begin
            translation_status_reg <= {hit_any, 11'h0,
                hit_any ? hit_phys : REQ.src[31:PAGE_LSB]};
        end
    end

    // Traps taken
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            trap_count <= 32'h0;
        end else if (trap) begin
            trap_count <= trap_count + 32'h1;
        end
    end

    // External reset pulse, core state untouched
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rst_cnt   <= 32'h0;
            RESET_OUT <= 1'b0;
        end else if (go && REQ.op == OP_RESET_DEVICES) begin
            rst_cnt   <= 32'(RESET_CYCLES - 1);
            RESET_OUT <= 1'b1;
        end else if (rst_cnt != 32'h0) begin
            rst_cnt <= rst_cnt - 32'h1;
        end else begin
            RESET_OUT <= 1'b0;
        end
    end

    // Register read, data in the next cycle
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            if (REG_ADDR[7:4] == REG_MMU_BASE[7:4]) begin
                REG_RDATA <= mmu_regs[REG_ADDR[3:2]];
            end else begin
                case (REG_ADDR)
                    REG_SOURCE_FC:   REG_RDATA <= {29'h0,
                                                   source_function_code};
                    REG_DEST_FC:     REG_RDATA <= {29'h0,
                                             destination_function_code};
                    REG_STATUS_WORD: REG_RDATA <= {16'h0, status_word};
                    REG_TSR:         REG_RDATA <= translation_status_reg;
                    REG_TRAP_COUNT:  REG_RDATA <= trap_count;
                    default:         REG_RDATA <= 32'h0;
                endcase
            end
        end else begin
            REG_RDATA <= 32'h0;
        end
    end

endmodule

// ---- bench/exec_properties.sv ----
`timescale 1ns/100ps
module exec_properties
    import exec_pkg::*;
#(parameter int RESET_CYCLES = 4) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic REQ_VALID,
    input wire req_s REQ,
    input wire logic RSP_VALID,
    input wire rsp_s RSP,
    input wire logic RESET_OUT
);
    req_s        prev;
    logic [31:0] cnt;
    wire         go = REQ_VALID && REQ.size == SZ_LONG && !REQ.to_mem;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // Request taken one edge earlier
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) prev <= '0;
        else prev <= REQ;
    end
    // Cycles the external reset has stood high
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) cnt <= 32'h0;
        else cnt <= RESET_OUT ? cnt + 32'h1 : 32'h0;
    end
    a_union_result: assert property (go && REQ.op == OP_UNION |=>
        RSP.result == (prev.src | prev.dst)) else $error("bad union");
    a_negate_value: assert property (go && REQ.op == OP_TWOS_COMPLEMENT_INV
        |=> RSP.result == 32'h0 - prev.dst) else $error("bad negate");
    a_invert_value: assert property (go && REQ.op == OP_BIT_INVERT |=>
        RSP.result == ~prev.dst) else $error("bad invert");
    a_word_product: assert property (REQ_VALID && REQ.size == SZ_WORD &&
        REQ.op == OP_UNSIGNED_MULTIPLY |=> RSP.result ==
        prev.src[15:0] * prev.dst[15:0]) else $error("bad product");
    a_push_step: assert property (go && REQ.op == OP_PUSH_EFFECTIVE_ADDR
        |=> RSP.ptr == prev.dst - PUSH_STEP && RSP.result == prev.ea)
        else $error("bad push");
    a_idle_quiet: assert property (REQ_VALID && REQ.op == OP_IDLE_INSTRUCTION
        |=> {RSP.trap, RSP.wr_dst, RSP.wr_mem, RSP.wr_ptr} == 4'h0)
        else $error("idle had effect");
    a_trap_quiet: assert property (RSP_VALID && RSP.trap |->
        {RSP.wr_dst, RSP.wr_hi, RSP.wr_mem, RSP.rd_mem, RSP.wr_ptr} == 5'h0)
        else $error("trap had effect");
    a_ccb_open: assert property (REQ_VALID && REQ.op == OP_IMM_UNION_CCB
        |=> RSP_VALID && !RSP.trap) else $error("ccb trapped");
    a_reset_start: assert property (REQ_VALID &&
        REQ.op == OP_RESET_DEVICES ##1 !RSP.trap |-> RESET_OUT)
        else $error("no reset out");
    a_reset_length: assert property ($fell(RESET_OUT) |->
        cnt == RESET_CYCLES) else $error("bad reset length");
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb
    import exec_pkg::*;
;
    logic        REF_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        REQ_VALID = 1'b0;
    req_s        REQ = '0;
    logic        RSP_VALID;
    rsp_s        RSP;
    logic        RESET_OUT;
    logic [7:0]  REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic        rd_d = 1'b0;
    logic [5:0]  rc = 6'h0;
    logic        tm = 1'b0;
    logic [31:0] a, b, m, r;
    logic [33:0] x;
    logic [33:0] exp_q[$];
    logic [31:0] rd_q[$];
    int          errors = 0;
    int          checks_done = 0;
    op_e         priv[7] = '{OP_ALTERNATE_SPACE_XFER, OP_IMM_UNION_STATUS_WORD,
        OP_TRANSLATION_INVAL, OP_TRANSLATION_PRELOAD, OP_MMU_REGISTER_XFER,
        OP_TRANSLATION_PROBE, OP_RESET_DEVICES};
    always #10 REF_CLK = ~REF_CLK;
    instruction_semantics_m_to_r #(.RESET_CYCLES(4))
        instruction_semantics_m_to_r_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
        .REQ_VALID(REQ_VALID), .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP),
        .RESET_OUT(RESET_OUT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
    task close_out;
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, want);
        end
    endtask
    // One instruction; note is {check result, trap, result}
    task issue(input op_e op, input size_e sz, input logic [31:0] s, d, e,
               input logic [33:0] note);
        @(posedge REF_CLK);
        REQ_VALID <= 1'b1;
        REQ <= '{op, sz, tm, 1'b0, 2'h1, rc, s, d, s, e};
        exp_q.push_back(note);
        @(posedge REF_CLK);
        REQ_VALID <= 1'b0;
    endtask
    // One register bus cycle, read when wr is low
    task reg_rw(input logic wr, input logic [7:0] ad, input logic [31:0] v);
        @(posedge REF_CLK);
        REG_WR <= wr;
        REG_RD <= !wr;
        REG_ADDR <= ad;
        REG_WDATA <= v;
        if (!wr) rd_q.push_back(v);
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
    endtask
    // Compare answers against the oldest notes
    always @(posedge REF_CLK) rd_d <= REG_RD;
    always @(negedge REF_CLK) begin
        if (RSP_VALID === 1'b1) begin
            x = exp_q.pop_front();
            cmp({31'h0, RSP.trap}, {31'h0, x[32]});
            if (x[33]) cmp(RSP.result, x[31:0]);
        end
        if (rd_d === 1'b1) cmp(REG_RDATA, rd_q.pop_front());
    end
    initial begin
        #1ms;
        errors++;
        close_out();
    end
    initial begin
        void'($urandom(32'hc05de4b1));
        repeat (12) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        reg_rw(1'b0, REG_STATUS_WORD, {16'h0, SR_RESET});
        reg_rw(1'b0, 8'h40, 32'h0);
        for (int i = 0; i < 8; i++) begin
            a = $urandom;
            b = $urandom;
            m = a[15:0] * b[15:0];
            r = b - PUSH_STEP;
            issue(OP_UNION, SZ_LONG, a, b, 0, {2'b10, a | b});
            issue(OP_TWOS_COMPLEMENT_INV, SZ_LONG, a, b, 0, {2'b10, -b});
            issue(OP_ZERO_MINUS_WITH_EXT, SZ_LONG, a, b, 0,
                  {2'b10, -b - {31'h0, |b}});
            issue(OP_IMMEDIATE_UNION, SZ_LONG, a, b, 0,
                  {2'b10, a | b});
            issue(OP_BIT_INVERT, SZ_LONG, a, b, 0, {2'b10, ~b});
            issue(OP_UNSIGNED_MULTIPLY, SZ_WORD, a, b, 0, {2'b10, m});
            issue(OP_PUSH_EFFECTIVE_ADDR, SZ_LONG, a, b, r, {2'b10, r});
        end
        issue(OP_IDLE_INSTRUCTION, SZ_LONG, a, b, 0, 34'h0);
        issue(OP_RESET_DEVICES, SZ_LONG, a, b, 0, 34'h0);
        issue(OP_MMU_REGISTER_XFER, SZ_LONG, a, b, 0, 34'h0);
        reg_rw(1'b0, REG_MMU_BASE + 8'h04, a);
        repeat (6) @(posedge REF_CLK);
        reg_rw(1'b1, REG_STATUS_WORD, 32'h0);
        for (int i = 0; i < 7; i++) begin
            issue(priv[i], SZ_LONG, b, a, b, {2'b01, 32'h0});
        end
        reg_rw(1'b0, REG_STATUS_WORD, 32'h0);
        reg_rw(1'b0, REG_MMU_BASE + 8'h04, a);
        reg_rw(1'b0, REG_TRAP_COUNT, 32'h7);
        issue(OP_IMM_UNION_CCB, SZ_BYTE, 32'h15, b, 0, 34'h0);
        reg_rw(1'b0, REG_STATUS_WORD, 32'h15);
        reg_rw(1'b1, REG_STATUS_WORD, {16'h0, SR_RESET});
        issue(OP_IMM_UNION_STATUS_WORD, SZ_WORD, 32'h8000, b, 0, 34'h0);
        reg_rw(1'b0, REG_STATUS_WORD, 32'ha700);
        // Memory-side forms, then the translation cache in supervisor state
        tm = 1'b1;
        issue(OP_ALTERNATE_SPACE_XFER, SZ_LONG, a, b, 0,
              {2'b10, a});
        rc = 6'h5;
        issue(OP_ROTATE_LEFT, SZ_LONG, a, 32'h5a5a8001, 0,
              {2'b10, 32'h5a5a0003});
        tm = 1'b0;
        issue(OP_TRANSLATION_PRELOAD, SZ_LONG, a, b, b, 34'h0);
        issue(OP_TRANSLATION_PROBE, SZ_LONG, 0, b, b, 34'h0);
        reg_rw(1'b0, REG_TSR, {1'b1, 11'h0, a[31:12]});
        issue(OP_TRANSLATION_INVAL, SZ_LONG, a, b, b, 34'h0);
        issue(OP_TRANSLATION_PROBE, SZ_LONG, 0, b, b, 34'h0);
        reg_rw(1'b0, REG_TSR, 32'h0);
        // Packing, decimal negate with the extend bit, rotates
        issue(OP_BCD_COMPRESS, SZ_BYTE, 32'h0102, b, 0,
              {2'b10, 32'h24});
        issue(OP_DECIMAL_ZERO_MINUS, SZ_BYTE, 0, 32'h12345645, 0,
              {2'b10, 32'h12345655});
        issue(OP_DECIMAL_ZERO_MINUS, SZ_BYTE, 0, 0, 0,
              {2'b10, 32'h99});
        rc = 6'h4;
        issue(OP_ROTATE_LEFT, SZ_LONG, a, b, 0,
              {2'b10, b[27:0], b[31:28]});
        rc = 6'h1;
        issue(OP_ROTATE_RIGHT, SZ_BYTE, a, 32'h12345681, 0,
              {2'b10, 32'h123456c0});
        issue(OP_EXTENDED_ROTATE_LEFT, SZ_LONG, a, 32'h80000000, 0,
              {2'b10, 32'h1});
        issue(OP_EXTENDED_ROTATE_RIGHT, SZ_LONG, a, 32'h2, 0,
              {2'b10, 32'h80000001});
        repeat (4) @(posedge REF_CLK);
        if (exp_q.size() != 0 || rd_q.size() != 0) errors++;
        close_out();
    end
endmodule
bind instruction_semantics_m_to_r exec_properties #(
    .RESET_CYCLES(RESET_CYCLES)) exec_properties_i (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .RSP_VALID(RSP_VALID), .RSP(RSP), .RESET_OUT(RESET_OUT));
